/* File: bench/bfp_bidir_fifo_checker.sv */
// Purpose: Port-level checks of the queue pair.
// Assumes: Both port domains share presetn.
// Notes: Bound into the top module.
`timescale 1ns/1ns
module bfp_bidir_fifo_checker
  import bfp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic port_a_select_n,
  input wire logic port_a_enable,
  input wire logic port_a_write,
  input wire logic port_a_mailbox_sel,
  input wire logic port_a_data_bus_oe_n,
  input wire logic port_a_empty_n,
  input wire logic port_a_almost_empty_n,
  input wire logic port_a_full_n,
  input wire logic a_to_b_mail_flag_n,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_enable,
  input wire logic port_b_write,
  input wire logic [1:0] port_b_size,
  input wire logic port_b_data_bus_oe_n,
  input wire logic port_b_empty_n,
  input wire logic port_b_almost_empty_n,
  input wire logic b_to_a_mail_flag_n
);
  ////////////////////////////////////////
  // Port A domain
  AST_OE_OFF_A: assert property (@(posedge pclk) disable iff (!presetn)
    port_a_select_n |-> port_a_data_bus_oe_n) else $error("A bus not released");
  AST_OE_ON_A: assert property (@(posedge pclk) disable iff (!presetn)
    !port_a_select_n && !port_a_write |-> !port_a_data_bus_oe_n) else $error("A not driven");
  // Full must wait two edges for the rdy_a ready shifter to fill
  AST_FULL_UP: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !port_a_full_n ##1 !port_a_full_n ##1 port_a_full_n)
    else $error("A full timing");
  AST_AE_A: assert property (@(posedge pclk) disable iff (!presetn)
    !port_a_empty_n |-> !port_a_almost_empty_n) else $error("A almost empty high");
  AST_MAIL_A: assert property (@(posedge pclk) disable iff (!presetn)
    !port_a_select_n && port_a_enable && port_a_write && port_a_mailbox_sel
    && a_to_b_mail_flag_n |=> !a_to_b_mail_flag_n) else $error("A mail flag");
  // Port B domain, then covers for both domains
  AST_OE_OFF_B: assert property (@(posedge port_b_clock) disable iff (!presetn)
    port_b_select_n |-> port_b_data_bus_oe_n) else $error("B bus not released");
  AST_AE_B: assert property (@(posedge port_b_clock) disable iff (!presetn)
    !port_b_empty_n |-> !port_b_almost_empty_n) else $error("B almost empty high");
  AST_MAIL_B: assert property (@(posedge port_b_clock) disable iff (!presetn)
    !port_b_select_n && port_b_enable && port_b_write && port_b_size == SIZE_MAIL
    && b_to_a_mail_flag_n |=> !b_to_a_mail_flag_n) else $error("B mail flag");
  cover property (@(posedge pclk) $fell(port_a_full_n));
  cover property (@(posedge pclk) $fell(a_to_b_mail_flag_n));
  cover property (@(posedge port_b_clock) $rose(port_b_empty_n));
endmodule
bind bfp_bidir_fifo bfp_bidir_fifo_checker bfp_bidir_fifo_checker_inst (.*);

/* File: bench/bfp_bidir_fifo_tb_top.sv */
// Purpose: Self-checking run over APB, port A and port B.
// Assumes: pclk also clocks port A.
// Notes: Expected values come from the rules.
`timescale 1ns/1ns
module bfp_bidir_fifo_tb_top
  import bfp_pkg::*;
;
  localparam logic [DATA_W-1:0] WD = 36'h9A5C3E1F7;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic port_a_select_n, port_a_enable, port_a_write, port_a_mailbox_sel;
  logic port_a_data_bus_oe_n, port_a_empty_n, port_a_almost_empty_n, port_a_full_n;
  logic port_a_almost_full_n, port_a_parity_err_n, a_to_b_mail_flag_n, port_b_clock;
  logic port_b_select_n, port_b_enable, port_b_write, endian_select, port_b_data_bus_oe_n;
  logic port_b_empty_n, port_b_almost_empty_n, port_b_full_n, port_b_almost_full_n;
  logic port_b_parity_err_n, b_to_a_mail_flag_n;
  logic [1:0] port_b_size, port_b_swap;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [DATA_W-1:0] port_a_data_bus_in, port_a_data_bus_out, q;
  logic [DATA_W-1:0] port_b_data_bus_in, port_b_data_bus_out;
  int n_mismatch = 0;
  int checks_done = 0;
  int i;
  ////////////////////////////////////////
  bfp_bidir_fifo bfp_bidir_fifo_inst (.*);
  bfp_port_b_model bfp_port_b_model_inst (.*);
  // 25 MHz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  // Compare and count
  task chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
    checks_done++;
    if (s !== x)
    begin
      $display("MISMATCH %0t seen %h exp %h", $time, s, x);
      n_mismatch++;
    end
  endtask
  task print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait; running out fails the run (f 3 never rises)
  task wait_hi(input int f);
    int k;
    for (k = 0; k < 400; k++)
    begin
      @(posedge pclk);
      if ((f == 0 ? port_a_empty_n : f == 1 ? port_b_empty_n :
        f == 2 ? a_to_b_mail_flag_n : 1'b0) === 1'b1)
        return;
    end
    n_mismatch++;
    print_verdict();
  endtask
  // APB transfer; request held until pready is seen
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
      wait_hi(3);
  endtask
  // One port A edge; q holds the word read
  task ax(input logic wr, input logic mb, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    port_a_select_n <= 1'b0;
    port_a_enable <= 1'b1;
    port_a_write <= wr;
    port_a_mailbox_sel <= mb;
    port_a_data_bus_in <= d;
    @(posedge pclk);
    port_a_select_n <= 1'b1;
    port_a_enable <= 1'b0;
    port_a_data_bus_in <= ~d;
    #1 q = port_a_data_bus_out;
  endtask
  task bx(input logic wr, input logic [1:0] sz, input logic [1:0] sw, input logic be,
    input logic [DATA_W-1:0] d);
    bfp_port_b_model_inst.xfer(wr, sz, sw, be, d, q);
  endtask
  // Splits WD into pieces per size and endian
  task b_put(input logic [1:0] sz, input logic be, input logic [1:0] sw);
    int n, k, s;
    logic [DATA_W-1:0] p;
    n = sz == SIZE_BYTE ? 4 : sz == SIZE_WORD ? 2 : 1;
    s = DATA_W / n;
    for (k = 0; k < n; k++)
    begin
      p = (WD >> ((be ? k : n - 1 - k) * s)) & ((36'h1 << s) - 36'h1);
      bx(1'b1, sz, sw, be, be ? p : p << (DATA_W - s));
    end
  endtask
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {port_a_enable, port_a_write, port_a_mailbox_sel, port_a_data_bus_in} = '0;
    port_a_select_n = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(r, CFG_RESET);
    apb(1'b0, 12'h00C, 32'h0);
    chk({r, e}, 33'h1);
    apb(1'b1, CFG_ADDR, 32'h102);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(r, 32'h102);
    // Fill to full with offset 2; extra bad-parity word refused but flagged
    for (i = 0; i < 64; i++)
    begin
      ax(1'b1, 1'b0, {4{9'(i)}});
      chk(port_a_almost_full_n, i < 61);
    end
    chk(port_a_full_n, 0);
    ax(1'b1, 1'b0, 36'h0);
    chk(port_a_parity_err_n, 0);
    wait_hi(1);
    chk(port_b_almost_empty_n, 1);
    for (i = 0; i < 64; i++)
    begin
      bx(1'b0, SIZE_LONG, SWAP_NONE, 1'b0, 36'h0);
      chk(q, {4{9'(i)}});
      chk(port_b_almost_empty_n, i < 61);
    end
    chk(port_b_empty_n, 0);
    // Narrow and swapped port B words read whole on A
    b_put(SIZE_BYTE, 1'b0, SWAP_NONE);
    b_put(SIZE_WORD, 1'b1, SWAP_NONE);
    b_put(SIZE_LONG, 1'b0, SWAP_BYTES);
    for (i = 0; i < 3; i++)
    begin
      wait_hi(0);
      ax(1'b0, 1'b0, 36'h0);
      chk(q, i < 2 ? WD : {WD[8:0], WD[17:9], WD[26:18], WD[35:27]});
    end
    // Second mail write ignored until B reads
    bx(1'b1, SIZE_MAIL, SWAP_NONE, 1'b0, ~WD);
    ax(1'b1, 1'b1, WD);
    chk(a_to_b_mail_flag_n, 0);
    ax(1'b1, 1'b1, 36'h0);
    bx(1'b0, SIZE_MAIL, SWAP_NONE, 1'b0, 36'h0);
    chk(q, WD);
    wait_hi(2);
    ax(1'b0, 1'b1, 36'h0);
    chk(q, ~WD);
    print_verdict();
  end
endmodule

/* File: bench/bfp_port_b_model.sv */
// Purpose: Port B master moving pieces and mailbox words.
// Assumes: One transfer per call, idle edge between calls.
// Notes: Makes its own free-running port B clock.
`timescale 1ns/1ns
module bfp_port_b_model
  import bfp_pkg::*;
(
  output logic port_b_clock,
  output logic port_b_select_n,
  output logic port_b_enable,
  output logic port_b_write,
  output logic [1:0] port_b_size,
  output logic [1:0] port_b_swap,
  output logic endian_select,
  output logic [DATA_W-1:0] port_b_data_bus_in,
  input wire logic [DATA_W-1:0] port_b_data_bus_out
);
  ////////////////////////////////////////
  // Free-running clock, unrelated to pclk
  initial port_b_clock = 1'b0;
  always #17 port_b_clock = ~port_b_clock;
  // Idle at time zero
  initial
  begin
    {port_b_enable, port_b_write, port_b_size, port_b_swap, endian_select} = '0;
    port_b_select_n = 1'b1;
    port_b_data_bus_in = '0;
  end
  // One enabled edge; released bus shows the inverse
  task automatic xfer(input logic wr, input logic [1:0] sz, input logic [1:0] sw,
    input logic be, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge port_b_clock);
    port_b_select_n <= 1'b0;
    port_b_enable <= 1'b1;
    port_b_write <= wr;
    port_b_size <= sz;
    port_b_swap <= sw;
    endian_select <= be;
    port_b_data_bus_in <= d;
    @(posedge port_b_clock);
    port_b_select_n <= 1'b1;
    port_b_enable <= 1'b0;
    port_b_data_bus_in <= ~d;
    #1 q = port_b_data_bus_out;
  endtask
endmodule

/* File: rtl/bfp_bidir_fifo.sv */
// Purpose: Queue pair with mailboxes, parity and port B sizing.
// Assumes: pclk clocks port A; port_b_clock is a second domain.
// Notes: Each port's pins follow its own clock.
// Behaviour
// - two 64x36 queues, opposite directions
// - transfers only on enabled rising port edges
// - port clocks independent, same-edge read/write allowed
// - full flags synchronised to writing port clock
// - empty flags synchronised to reading port clock
// - port A almost-empty low at level <= offset
// - port B almost-empty low at level <= offset
// - port A almost-full low at free <= offset
// - port B almost-full low at free <= offset
// - port B long, word, byte sizes packed
// - endian input picks most or least lanes
// - swap and size act on port B edges
// - port A select low to transfer, else released
// - two 36-bit mailboxes with new-mail flags
// - passive parity check, optional parity generation
// - port A is a 36-bit two-way bus
// - port A empty low at reset, second-edge rise
// - port A full low at reset, second-edge rise
// - mailbox write blocked until far side reads
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module bfp_bidir_fifo
  import bfp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_select_n,
  input wire logic port_a_enable,
  input wire logic port_a_write,
  input wire logic port_a_mailbox_sel,
  input wire logic [DATA_W-1:0] port_a_data_bus_in,
  output logic [DATA_W-1:0] port_a_data_bus_out,
  output logic port_a_data_bus_oe_n,
  output logic port_a_empty_n,
  output logic port_a_almost_empty_n,
  output logic port_a_full_n,
  output logic port_a_almost_full_n,
  output logic port_a_parity_err_n,
  output logic a_to_b_mail_flag_n,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_enable,
  input wire logic port_b_write,
  input wire logic [1:0] port_b_size,
  input wire logic [1:0] port_b_swap,
  input wire logic endian_select,
  input wire logic [DATA_W-1:0] port_b_data_bus_in,
  output logic [DATA_W-1:0] port_b_data_bus_out,
  output logic port_b_data_bus_oe_n,
  output logic port_b_empty_n,
  output logic port_b_almost_empty_n,
  output logic port_b_full_n,
  output logic port_b_almost_full_n,
  output logic port_b_parity_err_n,
  output logic b_to_a_mail_flag_n
);
  bfp_queue_if a_to_b_queue ();
  bfp_queue_if b_to_a_queue ();
  logic [1:0] rstb_s;
  logic rstb_n;
  logic [CFG_W-1:0] cfg_a;
  logic [CFG_W-1:0] cfg_b;
  logic cfg_tog;
  logic [2:0] cfg_tog_s;
  logic [31:0] status;
  logic addr_ok;
  logic [1:0] rdy_a;
  logic [1:0] rdy_b;
  logic a_go;
  logic a_show_mb;
  logic [DATA_W-1:0] a_to_b_mailbox;
  logic [DATA_W-1:0] b_to_a_mailbox;
  logic ab_wtog;
  logic ab_rtog;
  logic ba_wtog;
  logic ba_rtog;
  logic [1:0] ab_rtog_s;
  logic [1:0] ab_wtog_s;
  logic [1:0] ba_rtog_s;
  logic [1:0] ba_wtog_s;
  logic b_go;
  logic b_mb;
  logic [1:0] b_last;
  logic [1:0] bw_idx;
  logic [1:0] br_idx;
  logic [DATA_W-1:0] bw_acc;
  logic [DATA_W-1:0] b_wword;
  logic b_wr_ok;
  logic b_rd_ok;
  logic b_show_mb;
  logic [1:0] b_out_slot;
  logic [1:0] b_size_q;
  logic [1:0] b_swap_q;
  logic b_le_q;

  // Lane parity helpers; bit 8 of a lane is parity
  function automatic logic par_bad(input logic [DATA_W-1:0] w, input logic odd);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < LANES; i++)
    begin
      bad = bad | ((^w[i*BYTE_W +: BYTE_W]) != odd);
    end
    return bad;
  endfunction

  function automatic logic [DATA_W-1:0] par_gen(input logic [DATA_W-1:0] w, input logic odd);
    logic [DATA_W-1:0] r;
    r = w;
    for (int i = 0; i < LANES; i++)
    begin
      r[i*BYTE_W + BYTE_W - 1] = (^w[i*BYTE_W +: BYTE_W-1]) ^ odd;
    end
    return r;
  endfunction

  // Byte swap; each mode is its own inverse, so it serves both ways
  function automatic logic [DATA_W-1:0] swap36(input logic [DATA_W-1:0] w, input logic [1:0] m);
    logic [DATA_W-1:0] r;
    case (m)
      SWAP_BYTES: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      SWAP_WORDS: r = {w[17:0], w[35:18]};
      SWAP_IN_WORD: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: r = w;
    endcase
    return r;
  endfunction

  // Slot of a piece; big-endian sends the top slot first
  function automatic logic [1:0] slot_of(input logic [1:0] idx, input logic [1:0] sz,
                                         input logic le);
    logic [1:0] s;
    s = IDX_ZERO;
    if (sz == SIZE_WORD)
      s = {1'b0, le ? idx[0] : ~idx[0]};
    else if (sz == SIZE_BYTE)
      s = le ? idx : IDX_BYTE_LAST - idx;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Port B reset: asserts at once, releases on port B clock
  always_ff @(posedge port_b_clock or negedge presetn)
  begin
    if (!presetn)
      rstb_s <= RDY_RESET;
    else
      rstb_s <= {rstb_s[0], 1'b1};
  end
  assign rstb_n = rstb_s[1];

  // Queues; pointer crossing lives inside
  bfp_queue u_a_to_b (.wclk(pclk), .wrst_n(presetn), .rclk(port_b_clock), .rrst_n(rstb_n),
    .q(a_to_b_queue));
  bfp_queue u_b_to_a (.wclk(port_b_clock), .wrst_n(rstb_n), .rclk(pclk), .rrst_n(presetn),
    .q(b_to_a_queue));

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus: zero wait states, read data captured in the setup cycle
  assign addr_ok = (paddr == CFG_ADDR) || (paddr == STAT_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    status = '0;
    status[ST_FLAG_LSB +: 8] = {(ba_wtog_s[1] != ba_rtog), a_to_b_mail_flag_n,
      port_a_parity_err_n, port_a_almost_full_n, port_a_full_n,
      port_a_almost_empty_n, port_a_empty_n, rdy_a[1]};
    status[ST_AB_LSB +: PTR_W] = a_to_b_queue.wcount;
    status[ST_BA_LSB +: PTR_W] = b_to_a_queue.rcount;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= (paddr == CFG_ADDR) ? 32'(cfg_a) : (paddr == STAT_ADDR) ? status : 32'h0;
  end

  // Config write; a toggle tells port B a new value is held stable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_a <= CFG_RESET;
      cfg_tog <= 1'b0;
    end
    else if (psel && penable && pwrite && paddr == CFG_ADDR)
    begin
      cfg_a <= pwdata[CFG_W-1:0];
      cfg_tog <= ~cfg_tog;
    end
  end

  // Config into port B; leave a few port B edges between writes
  always_ff @(posedge port_b_clock or negedge rstb_n)
  begin
    if (!rstb_n)
    begin
      cfg_tog_s <= 3'h0;
      cfg_b <= CFG_RESET;
    end
    else
    begin
      cfg_tog_s <= {cfg_tog_s[1:0], cfg_tog};
      if (cfg_tog_s[2] != cfg_tog_s[1])
        cfg_b <= cfg_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port A transfers gated by select and enable
  assign a_go = !port_a_select_n && port_a_enable;
  assign a_to_b_queue.push = a_go && port_a_write && !port_a_mailbox_sel && port_a_full_n;
  assign a_to_b_queue.wdata = port_a_data_bus_in;
  assign b_to_a_queue.pop = a_go && !port_a_write && !port_a_mailbox_sel && port_a_empty_n;

  // Port A flags; the rdy_a shifter gives full its two stages after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdy_a <= RDY_RESET;
    else
      rdy_a <= {rdy_a[0], 1'b1};
  end
  assign port_a_full_n = rdy_a[1] && (a_to_b_queue.wcount != DEPTH_CNT);
  assign port_a_almost_full_n =
    (DEPTH_CNT - a_to_b_queue.wcount) > {1'b0, cfg_a[CFG_X_LSB +: CFG_X_W]};
  assign port_a_empty_n = b_to_a_queue.rcount != CNT_ZERO;
  assign port_a_almost_empty_n =
    b_to_a_queue.rcount > {1'b0, cfg_a[CFG_X_LSB +: CFG_X_W]};

  // Port A mailbox write, refused while earlier mail is unread
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_to_b_mailbox <= '0;
      ab_wtog <= 1'b0;
    end
    else if (a_go && port_a_write && port_a_mailbox_sel && a_to_b_mail_flag_n)
    begin
      a_to_b_mailbox <= port_a_data_bus_in;
      ab_wtog <= ~ab_wtog;
    end
  end

  // Port A handshakes, mailbox read, parity check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_rtog_s <= 2'h0;
      ba_wtog_s <= 2'h0;
      ba_rtog <= 1'b0;
      a_show_mb <= 1'b0;
      port_a_parity_err_n <= 1'b1;
    end
    else
    begin
      ab_rtog_s <= {ab_rtog_s[0], ab_rtog};
      ba_wtog_s <= {ba_wtog_s[0], ba_wtog};
      port_a_parity_err_n <= !par_bad(port_a_data_bus_in, cfg_a[CFG_ODD]);
      if (a_go && !port_a_write)
        a_show_mb <= port_a_mailbox_sel;
      if (a_go && !port_a_write && port_a_mailbox_sel && ba_wtog_s[1] != ba_rtog)
        ba_rtog <= ~ba_rtog;
    end
  end
  assign a_to_b_mail_flag_n = ab_wtog == ab_rtog_s[1];

  // Port A drive; released unless selected for a read
  always_comb
  begin
    port_a_data_bus_out = a_show_mb ? b_to_a_mailbox : b_to_a_queue.rdata;
    if (cfg_a[CFG_GEN_A])
      port_a_data_bus_out = par_gen(port_a_data_bus_out, cfg_a[CFG_ODD]);
  end
  assign port_a_data_bus_oe_n = port_a_select_n || port_a_write;

  ////////////////////////////////////////////////////////////////////////////////
  // Port B transfer qualification and piece counts
  assign b_go = !port_b_select_n && port_b_enable;
  assign b_mb = port_b_size == SIZE_MAIL;
  assign b_last = (port_b_size == SIZE_WORD) ? IDX_WORD_LAST :
                  (port_b_size == SIZE_BYTE) ? IDX_BYTE_LAST : IDX_ZERO;
  assign b_wr_ok = b_go && port_b_write && !b_mb && port_b_full_n;
  assign b_rd_ok = b_go && !port_b_write && !b_mb &&
                   (br_idx != IDX_ZERO || a_to_b_queue.rcount != CNT_ZERO);

  // Merge the incoming piece into the word being built
  always_comb
  begin
    logic [1:0] s;
    s = slot_of(bw_idx, port_b_size, endian_select);
    b_wword = bw_acc;
    if (port_b_size == SIZE_WORD)
      b_wword = bw_acc | ({18'h0, endian_select ? port_b_data_bus_in[17:0] :
        port_b_data_bus_in[35:18]} << (s[0] ? 6'd18 : 6'd0));
    else if (port_b_size == SIZE_BYTE)
      b_wword = bw_acc | ({27'h0, endian_select ? port_b_data_bus_in[8:0] :
        port_b_data_bus_in[35:27]} << (s * 5'd9));
    else
      b_wword = port_b_data_bus_in;
  end
  assign b_to_a_queue.push = b_wr_ok && bw_idx == b_last;
  assign b_to_a_queue.wdata = swap36(b_wword, port_b_swap);
  assign a_to_b_queue.pop = b_rd_ok && br_idx == IDX_ZERO;

  // Piece counters; sizing sampled on each enabled port B read edge
  always_ff @(posedge port_b_clock or negedge rstb_n)
  begin
    if (!rstb_n)
    begin
      bw_idx <= IDX_ZERO;
      bw_acc <= '0;
      br_idx <= IDX_ZERO;
      b_out_slot <= IDX_ZERO;
      b_size_q <= SIZE_LONG;
      b_swap_q <= SWAP_NONE;
      b_le_q <= 1'b0;
      b_show_mb <= 1'b0;
    end
    else
    begin
      if (b_wr_ok)
      begin
        bw_idx <= (bw_idx == b_last) ? IDX_ZERO : bw_idx + 2'h1;
        bw_acc <= (bw_idx == b_last) ? '0 : b_wword;
      end
      if (b_go && !port_b_write)
      begin
        b_size_q <= port_b_size;
        b_swap_q <= port_b_swap;
        b_le_q <= endian_select;
        b_show_mb <= b_mb;
      end
      if (b_rd_ok)
      begin
        b_out_slot <= slot_of(br_idx, port_b_size, endian_select);
        br_idx <= (br_idx == b_last) ? IDX_ZERO : br_idx + 2'h1;
      end
    end
  end

  // Port B flags from the synchronised pointers
  always_ff @(posedge port_b_clock or negedge rstb_n)
  begin
    if (!rstb_n)
      rdy_b <= RDY_RESET;
    else
      rdy_b <= {rdy_b[0], 1'b1};
  end
  assign port_b_full_n = rdy_b[1] && (b_to_a_queue.wcount != DEPTH_CNT);
  assign port_b_almost_full_n =
    (DEPTH_CNT - b_to_a_queue.wcount) > {1'b0, cfg_b[CFG_X_LSB +: CFG_X_W]};
  // A partly sent word still counts as data, else a narrow reader would stall
  assign port_b_empty_n = a_to_b_queue.rcount != CNT_ZERO || br_idx != IDX_ZERO;
  assign port_b_almost_empty_n =
    a_to_b_queue.rcount > {1'b0, cfg_b[CFG_X_LSB +: CFG_X_W]};

  // Port B mailbox write and handshakes
  always_ff @(posedge port_b_clock or negedge rstb_n)
  begin
    if (!rstb_n)
    begin
      b_to_a_mailbox <= '0;
      ba_wtog <= 1'b0;
      ab_rtog <= 1'b0;
      ab_wtog_s <= 2'h0;
      ba_rtog_s <= 2'h0;
      port_b_parity_err_n <= 1'b1;
    end
    else
    begin
      ab_wtog_s <= {ab_wtog_s[0], ab_wtog};
      ba_rtog_s <= {ba_rtog_s[0], ba_rtog};
      port_b_parity_err_n <= !par_bad(port_b_data_bus_in, cfg_b[CFG_ODD]);
      if (b_go && port_b_write && b_mb && b_to_a_mail_flag_n)
      begin
        b_to_a_mailbox <= port_b_data_bus_in;
        ba_wtog <= ~ba_wtog;
      end
      if (b_go && !port_b_write && b_mb && ab_wtog_s[1] != ab_rtog)
        ab_rtog <= ~ab_rtog;
    end
  end
  assign b_to_a_mail_flag_n = ba_wtog == ba_rtog_s[1];

  // Port B drive: unswap the word, pick the piece and move it to its lanes
  always_comb
  begin
    logic [DATA_W-1:0] w;
    w = swap36(a_to_b_queue.rdata, b_swap_q) >> (b_size_q == SIZE_WORD ?
      (b_out_slot[0] ? 6'd18 : 6'd0) : (b_out_slot * 5'd9));
    if (b_show_mb)
      port_b_data_bus_out = a_to_b_mailbox;
    else if (b_size_q == SIZE_WORD)
      port_b_data_bus_out = b_le_q ? {18'h0, w[17:0]} : {w[17:0], 18'h0};
    else if (b_size_q == SIZE_BYTE)
      port_b_data_bus_out = b_le_q ? {27'h0, w[8:0]} : {w[8:0], 27'h0};
    else
      port_b_data_bus_out = w;
    if (cfg_b[CFG_GEN_B])
      port_b_data_bus_out = par_gen(port_b_data_bus_out, cfg_b[CFG_ODD]);
  end
  assign port_b_data_bus_oe_n = port_b_select_n || port_b_write;
endmodule

/* File: rtl/bfp_pkg.sv */
// Purpose: Shared constants of the bidirectional queue pair.
// Assumes: 36-bit words of four 9-bit lanes, lane bit 8 is parity.
// Notes: Register map and port B codes.
package bfp_pkg;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int LANES = 4;
  localparam int DEPTH = 64;
  localparam int PTR_W = 7;
  localparam logic [6:0] PTR_ONE = 7'h01;
  localparam logic [6:0] DEPTH_CNT = 7'h40;
  localparam logic [6:0] CNT_ZERO = 7'h00;
  // Register bus map
  localparam int ADDR_W = 12;
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  // Config register fields
  localparam int CFG_W = 11;
  localparam int CFG_X_LSB = 0;
  localparam int CFG_X_W = 6;
  localparam int CFG_ODD = 8;
  localparam int CFG_GEN_A = 9;
  localparam int CFG_GEN_B = 10;
  localparam logic [10:0] CFG_RESET = 11'h008;
  // Status register fields
  localparam int ST_FLAG_LSB = 0;
  localparam int ST_AB_LSB = 8;
  localparam int ST_BA_LSB = 16;
  // Port B bus size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_BYTE = 2'h2;
  localparam logic [1:0] SIZE_MAIL = 2'h3;
  // Port B swap codes
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_BYTES = 2'h1;
  localparam logic [1:0] SWAP_WORDS = 2'h2;
  localparam logic [1:0] SWAP_IN_WORD = 2'h3;
  // Piece counters and reset-ready shifters
  localparam logic [1:0] IDX_ZERO = 2'h0;
  localparam logic [1:0] IDX_WORD_LAST = 2'h1;
  localparam logic [1:0] IDX_BYTE_LAST = 2'h3;
  localparam logic [1:0] RDY_RESET = 2'h0;
endpackage

/* File: rtl/bfp_queue.sv */
// Purpose: One 64 x 36 dual-clock queue with gray-coded pointer crossing.
// Assumes: The caller never pushes when full nor pops when empty.
// Notes: Read data comes out of a register one edge after pop.
`timescale 1ns/1ns
module bfp_queue
  import bfp_pkg::*;
(
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic rclk,
  input wire logic rrst_n,
  bfp_queue_if.queue q
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [PTR_W-1:0] wgray;
  logic [PTR_W-1:0] rgray;
  logic [PTR_W-1:0] rg_s1;
  logic [PTR_W-1:0] rg_s2;
  logic [PTR_W-1:0] wg_s1;
  logic [PTR_W-1:0] wg_s2;
  logic [PTR_W-1:0] next_wptr;
  logic [PTR_W-1:0] next_rptr;

  function automatic logic [PTR_W-1:0] gray_to_bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  assign next_wptr = wptr + PTR_ONE;
  assign next_rptr = rptr + PTR_ONE;

  ////////////////////////////////////////////////////////////////////////////////
  // Write side; extra pointer bit tells full from empty
  always_ff @(posedge wclk or negedge wrst_n)
  begin
    if (!wrst_n)
    begin
      wptr <= CNT_ZERO;
      wgray <= CNT_ZERO;
    end
    else if (q.push)
    begin
      wptr <= next_wptr;
      wgray <= next_wptr ^ (next_wptr >> 1);
    end
  end

  // Storage; no reset, empty slots are never read
  always_ff @(posedge wclk)
  begin
    if (q.push)
    begin
      mem[wptr[PTR_W-2:0]] <= q.wdata;
    end
  end

  // Read side with registered output word
  always_ff @(posedge rclk or negedge rrst_n)
  begin
    if (!rrst_n)
    begin
      rptr <= CNT_ZERO;
      rgray <= CNT_ZERO;
      q.rdata <= '0;
    end
    else if (q.pop)
    begin
      rptr <= next_rptr;
      rgray <= next_rptr ^ (next_rptr >> 1);
      q.rdata <= mem[rptr[PTR_W-2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage pointer crossing; gray code changes one bit a step
  always_ff @(posedge wclk or negedge wrst_n)
  begin
    if (!wrst_n)
    begin
      rg_s1 <= CNT_ZERO;
      rg_s2 <= CNT_ZERO;
    end
    else
    begin
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n)
  begin
    if (!rrst_n)
    begin
      wg_s1 <= CNT_ZERO;
      wg_s2 <= CNT_ZERO;
    end
    else
    begin
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
    end
  end

  // Fill levels as seen from each side
  assign q.wcount = wptr - gray_to_bin(rg_s2);
  assign q.rcount = gray_to_bin(wg_s2) - rptr;
endmodule

/* File: rtl/bfp_queue_if.sv */
// Purpose: Links the port logic to one storage queue.
// Assumes: push in the write domain, pop in the read domain.
// Notes: wcount is valid in the write domain, rcount in the read domain.
`timescale 1ns/1ns
interface bfp_queue_if;
  import bfp_pkg::*;
  logic push;
  logic [DATA_W-1:0] wdata;
  logic pop;
  logic [DATA_W-1:0] rdata;
  logic [PTR_W-1:0] wcount;
  logic [PTR_W-1:0] rcount;
  modport ctl (output push, output wdata, output pop, input rdata, input wcount, input rcount);
  modport queue (input push, input wdata, input pop, output rdata, output wcount, output rcount);
endinterface
